//--- rtl/prm_power_ctrl.sv
// power reduction mode control: idle and power-down sequencer with apb registers
//
// Contract
// - idle halts cpu, peripherals keep running
// - any interrupt ends idle, cpu resumes
// - pending external bus transfer finishes first
// - missing ready on last access refuses entry
// - power-down stops clock, freezes watchdog too
// - only rtc may count in power-down
// - low-power oscillator running: main oscillator stops
// - detect low-power oscillator, keep until disabled
// - main oscillator only: keep it running; here it stops unless the rtc keeps counting
// - variant bit zero selects protected power-down
// - protected power-down needs nmi pin low
// - protected power-down leaves only by reset
// - variant bit one selects interruptible power-down
// - enabled fast interrupt pins inactive for entry
// - reset, fast pin, rtc, can, i2c wake
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ns
module prm_power_ctrl
   import prm_pkg::*;
#(
   parameter int EXT_PINS = 8
) (
   input wire logic clock,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu instruction stream, same clock
   input wire logic idle_instr,
   input wire logic power_down_instr,
   input wire logic cpu_irq_req,
   // external bus unit, same clock
   input wire logic ext_bus_busy,
   input wire logic ext_bus_access_end,
   // pins, asynchronous
   input wire logic ready_pin,
   input wire logic nmi_pin_n,
   input wire logic [EXT_PINS-1:0] fast_ext_interrupt_pin,
   input wire logic lp_osc_running,
   // peripheral wake requests, same clock
   input wire logic rtc_irq,
   input wire logic can_irq,
   input wire logic i2c_irq,
   // control outputs
   output logic cpu_halt,
   output logic core_clk_en,
   output logic periph_clk_en,
   output logic wdt_hold,
   output logic main_osc_en,
   output logic rtc_ref_low_power,
   output logic rtc_clk_en,
   output logic regulator_off,
   output logic wake_irq_pending,
   output logic irq
);

   prm_state_t state_q;
   logic pd_req_q;
   logic [31:0] syscfg_q;
   logic reg_off_q;
   logic [1:0] rtccfg_q;
   logic [2*EXT_PINS-1:0] extcfg_q;
   logic [1:0] buscfg_q;
   logic [PRM_EV_W-1:0] irq_st_q;
   logic [PRM_EV_W-1:0] irq_en_q;
   logic [PRM_EV_W-1:0] ev;
   logic ready_ok_q;
   logic lp_sel_q;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;

   // two-flop synchronisers for every pin
   logic ready_s1_q, ready_s2_q;
   logic nmi_s1_q, nmi_s2_q;
   logic lp_s1_q, lp_s2_q;
   logic [EXT_PINS-1:0] ext_s1_q, ext_s2_q;

   // outputs, all flops
   logic cpu_halt_q, core_clk_en_q, periph_clk_en_q, wdt_hold_q;
   logic main_osc_en_q, rtc_clk_en_q, wake_irq_q, irq_q;

   logic setup_ph, wr_acc;
   logic [EXT_PINS-1:0] ext_active;
   logic ext_quiet, ready_fail, pd_variant, entry_ok, wake_int, enter;

   // synchronisers: only the second stage feeds logic
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ready_s1_q <= 1'b0;
         ready_s2_q <= 1'b0;
         nmi_s1_q <= 1'b1;
         nmi_s2_q <= 1'b1;
         lp_s1_q <= 1'b0;
         lp_s2_q <= 1'b0;
         ext_s1_q <= '0;
         ext_s2_q <= '0;
      end else begin
         ready_s1_q <= ready_pin;
         ready_s2_q <= ready_s1_q;
         nmi_s1_q <= nmi_pin_n;
         nmi_s2_q <= nmi_s1_q;
         lp_s1_q <= lp_osc_running;
         lp_s2_q <= lp_s1_q;
         ext_s1_q <= fast_ext_interrupt_pin;
         ext_s2_q <= ext_s1_q;
      end
   end

   // bus decode: answer is prepared in the setup phase so pready comes from a flop
   assign setup_ph = psel & ~penable;
   assign wr_acc = psel & penable & pwrite & pready_q;

   // entry conditions
   // a pin is active when its level matches the programmed active level
   assign ext_active = ~(ext_s2_q ^ extcfg_q[PRM_EXT_LEVEL_LSB +: EXT_PINS]);
   assign ext_quiet = ~|(ext_active & extcfg_q[EXT_PINS-1:0]);
   assign ready_fail = buscfg_q[PRM_READY_EN_BIT] & ~ready_ok_q;
   assign pd_variant = syscfg_q[PRM_PD_VARIANT_BIT];
   // variant 0 protected needs nmi low, variant 1 needs quiet fast pins
   assign entry_ok = pd_variant ? ext_quiet : ~nmi_s2_q;
   assign enter = (state_q == PRM_RUN) & (idle_instr | power_down_instr) & ~ready_fail &
                  (idle_instr | entry_ok);
   // interruptible power-down wake sources besides reset
   assign wake_int = |(ext_active & extcfg_q[EXT_PINS-1:0]) | rtc_irq | can_irq |
                     i2c_irq;

   // event pulses for the sticky status
   always_comb begin
      ev = '0;
      ev[PRM_EV_REFUSED] = (state_q == PRM_RUN) & (idle_instr | power_down_instr) & ~enter;
      ev[PRM_EV_WAKE] = (state_q == PRM_PD_INT) & wake_int;
      ev[PRM_EV_LP_FOUND] = lp_s2_q & ~lp_sel_q & ~rtccfg_q[PRM_LP_DISABLE_BIT];
      ev[PRM_EV_REG_ON] = (state_q == PRM_DRAIN) & pd_req_q & ~ext_bus_busy & ~reg_off_q;
   end

   // ready handshake seen at its programmed polarity on the last bus access
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ready_ok_q <= 1'b1;
      end else if (ext_bus_access_end) begin
         ready_ok_q <= (ready_s2_q == buscfg_q[PRM_READY_POL_BIT]);
      end
   end

   // low-power reference: picked as soon as seen, kept until software drops it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lp_sel_q <= 1'b0;
      end else if (rtccfg_q[PRM_LP_DISABLE_BIT]) begin
         lp_sel_q <= 1'b0;
      end else if (lp_s2_q) begin
         lp_sel_q <= 1'b1;
      end
   end

   // mode sequencer
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         state_q <= PRM_RUN;
         pd_req_q <= 1'b0;
      end else begin
         unique case (state_q)
            PRM_RUN: begin
               if (enter) begin
                  state_q <= PRM_DRAIN;
                  pd_req_q <= power_down_instr;
               end
            end
            PRM_DRAIN: begin
               // hold off until the external bus unit has nothing in flight
               if (!ext_bus_busy) begin
                  if (!pd_req_q) begin
                     state_q <= PRM_IDLE;
                  end else if (pd_variant) begin
                     state_q <= PRM_PD_INT;
                  end else begin
                     state_q <= PRM_PD_PROT;
                  end
               end
            end
            PRM_IDLE: begin
               // any request ends idle; the cpu resumes after its return
               if (cpu_irq_req | wake_int) begin
                  state_q <= PRM_RUN;
               end
            end
            PRM_PD_INT: begin
               if (wake_int) begin
                  state_q <= PRM_WAKE;
               end
            end
            PRM_PD_PROT: begin
               // no exit edge here: only nrst leaves this state
               state_q <= PRM_PD_PROT;
            end
            PRM_WAKE: begin
               state_q <= PRM_RUN;
            end
            default: begin
               state_q <= PRM_RUN;
            end
         endcase
      end
   end

   // clock and halt controls derived from the next state so they change with it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         cpu_halt_q <= 1'b0;
         core_clk_en_q <= 1'b1;
         periph_clk_en_q <= 1'b1;
         wdt_hold_q <= 1'b0;
      end else begin
         unique case (state_q)
            PRM_DRAIN: begin
               if (!ext_bus_busy) begin
                  cpu_halt_q <= 1'b1;
                  core_clk_en_q <= ~pd_req_q;
                  periph_clk_en_q <= ~pd_req_q;
                  wdt_hold_q <= pd_req_q;
               end
            end
            PRM_IDLE: begin
               if (cpu_irq_req | wake_int) begin
                  cpu_halt_q <= 1'b0;
               end
            end
            PRM_PD_INT: begin
               if (wake_int) begin
                  // restart clocks a cycle before the cpu runs again
                  core_clk_en_q <= 1'b1;
                  periph_clk_en_q <= 1'b1;
                  wdt_hold_q <= 1'b0;
               end
            end
            PRM_WAKE: begin
               cpu_halt_q <= 1'b0;
            end
            default: begin
               cpu_halt_q <= cpu_halt_q;
            end
         endcase
      end
   end

   // oscillator and rtc clock: rtc is the only thing that may still count
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         main_osc_en_q <= 1'b1;
         rtc_clk_en_q <= 1'b1;
      end else if (state_q == PRM_DRAIN && !ext_bus_busy && pd_req_q) begin
         rtc_clk_en_q <= rtccfg_q[PRM_RTC_PD_RUN_BIT];
         // low-power reference lets the main oscillator stop, else it stays on only while the rtc keeps counting
         main_osc_en_q <= rtccfg_q[PRM_RTC_PD_RUN_BIT] & ~lp_sel_q;
      end else if (state_q == PRM_PD_INT && wake_int) begin
         main_osc_en_q <= 1'b1;
         rtc_clk_en_q <= 1'b1;
      end
   end

   // wake interrupt handed to the cpu, held until it asks for service
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         wake_irq_q <= 1'b0;
      end else if (state_q == PRM_PD_INT && wake_int) begin
         wake_irq_q <= 1'b1;
      end else if (cpu_irq_req && state_q == PRM_RUN) begin
         wake_irq_q <= 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         syscfg_q <= PRM_SYSCFG_RST;
         reg_off_q <= 1'b0;
         rtccfg_q <= 2'h0;
         extcfg_q <= PRM_EXTCFG_RST[2*EXT_PINS-1:0];
         buscfg_q <= 2'h0;
         irq_en_q <= '0;
      end else if (wr_acc) begin
         unique case (paddr)
            PRM_SYSCFG_OFF: syscfg_q <= pwdata;
            PRM_MISC_OFF: reg_off_q <= pwdata[PRM_REG_OFF_BIT];
            PRM_RTCCFG_OFF: rtccfg_q <= pwdata[1:0];
            PRM_EXTCFG_OFF: extcfg_q <= pwdata[2*EXT_PINS-1:0];
            PRM_BUSCFG_OFF: buscfg_q <= pwdata[1:0];
            PRM_IRQEN_OFF: irq_en_q <= pwdata[PRM_EV_W-1:0];
            default: irq_en_q <= irq_en_q;
         endcase
      end
   end

   // sticky events: a new event in the clearing cycle survives the clear
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_st_q <= '0;
      end else if (wr_acc && paddr == PRM_IRQCLR_OFF) begin
         irq_st_q <= (irq_st_q & ~pwdata[PRM_EV_W-1:0]) | ev;
      end else begin
         irq_st_q <= irq_st_q | ev;
      end
   end

   // level interrupt, one cycle behind the status
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_st_q & irq_en_q);
      end
   end

   // read data and answer prepared during setup; zero wait states
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         prdata_q <= 32'h0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         pready_q <= setup_ph;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0;
         if (setup_ph) begin
            unique case (paddr)
               PRM_SYSCFG_OFF: prdata_q <= syscfg_q;
               PRM_MISC_OFF: prdata_q <= {31'h0, reg_off_q};
               PRM_RTCCFG_OFF: prdata_q <= {30'h0, rtccfg_q};
               PRM_EXTCFG_OFF: prdata_q <= {{(32-2*EXT_PINS){1'b0}}, extcfg_q};
               PRM_BUSCFG_OFF: prdata_q <= {30'h0, buscfg_q};
               PRM_STATE_OFF: prdata_q <= {24'h0, lp_sel_q, ready_ok_q, wake_irq_q,
                                           pd_req_q, 1'b0, state_q};
               PRM_IRQST_OFF: prdata_q <= {{(32-PRM_EV_W){1'b0}}, irq_st_q};
               PRM_IRQEN_OFF: prdata_q <= {{(32-PRM_EV_W){1'b0}}, irq_en_q};
               PRM_IRQCLR_OFF: prdata_q <= 32'h0;
               default: pslverr_q <= 1'b1; // unmapped address
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign cpu_halt = cpu_halt_q;
   assign core_clk_en = core_clk_en_q;
   assign periph_clk_en = periph_clk_en_q;
   assign wdt_hold = wdt_hold_q;
   assign main_osc_en = main_osc_en_q;
   assign rtc_ref_low_power = lp_sel_q;
   assign rtc_clk_en = rtc_clk_en_q;
   assign regulator_off = reg_off_q;
   assign wake_irq_pending = wake_irq_q;
   assign irq = irq_q;

endmodule

//--- rtl/prm_pkg.sv
// constants, register map and state encoding of the power reduction mode control
package prm_pkg;

   // register byte offsets on the apb bus
   localparam logic [7:0] PRM_SYSCFG_OFF = 8'h00;  // system_config_register
   localparam logic [7:0] PRM_MISC_OFF = 8'h04;    // misc_control_register
   localparam logic [7:0] PRM_RTCCFG_OFF = 8'h08;  // rtc reference control
   localparam logic [7:0] PRM_EXTCFG_OFF = 8'h0c;  // fast interrupt enables/levels
   localparam logic [7:0] PRM_BUSCFG_OFF = 8'h10;  // ready handshake control
   localparam logic [7:0] PRM_STATE_OFF = 8'h14;   // live state, read only
   localparam logic [7:0] PRM_IRQST_OFF = 8'h18;   // sticky events, read only
   localparam logic [7:0] PRM_IRQEN_OFF = 8'h1c;   // event enables
   localparam logic [7:0] PRM_IRQCLR_OFF = 8'h20;  // write one to clear, write only

   // field positions
   localparam int PRM_PD_VARIANT_BIT = 5;   // power_down_variant_bit in system config
   localparam int PRM_REG_OFF_BIT = 0;      // regulator_off_bit in misc control
   localparam int PRM_RTC_PD_RUN_BIT = 0;   // rtc keeps counting in power-down
   localparam int PRM_LP_DISABLE_BIT = 1;   // software drops the low-power reference
   localparam int PRM_READY_EN_BIT = 0;     // ready handshake enabled
   localparam int PRM_READY_POL_BIT = 1;    // 1: ready active high
   localparam int PRM_EXT_LEVEL_LSB = 8;    // active-level bits follow the enables

   // event bits of the interrupt registers
   localparam int PRM_EV_REFUSED = 0;   // idle/power-down request refused
   localparam int PRM_EV_WAKE = 1;      // left interruptible power-down
   localparam int PRM_EV_LP_FOUND = 2;  // low-power oscillator detected
   localparam int PRM_EV_REG_ON = 3;    // power-down entered with regulator left on
   localparam int PRM_EV_W = 4;

   // reset values
   localparam logic [31:0] PRM_SYSCFG_RST = 32'h0000_0000;
   localparam logic [31:0] PRM_EXTCFG_RST = 32'h0000_0000;

   // wake pulse on a fast interrupt pin, shortest as printed
   localparam int PRM_CLK_PERIOD_NS = 50;
   localparam int PRM_WAKE_MIN_NS = 40;
   localparam int PRM_WAKE_MIN_CYC = (PRM_WAKE_MIN_NS + PRM_CLK_PERIOD_NS - 1) /
                                     PRM_CLK_PERIOD_NS;

   // mode sequencer, gray in listed order; only the run -> drain -> idle steps change a single bit
   typedef enum logic [2:0] {
      PRM_RUN = 3'b000,
      PRM_DRAIN = 3'b001,
      PRM_IDLE = 3'b011,
      PRM_PD_INT = 3'b010,
      PRM_PD_PROT = 3'b110,
      PRM_WAKE = 3'b111
   } prm_state_t;

endpackage

//--- dv/prm_power_ctrl_assertions.sv
// concurrent checks on the power reduction mode control ports
`timescale 1ns/1ns
module prm_power_ctrl_checker import prm_pkg::*; (
   input wire logic clock,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic cpu_irq_req,
   input wire logic ext_bus_busy,
   input wire logic rtc_irq,
   input wire logic can_irq,
   input wire logic i2c_irq,
   input wire logic cpu_halt,
   input wire logic core_clk_en,
   input wire logic periph_clk_en,
   input wire logic wdt_hold,
   input wire logic main_osc_en,
   input wire logic rtc_ref_low_power,
   input wire logic rtc_clk_en,
   input wire logic wake_irq_pending
);
   logic pd_var_q;
   logic dis_wr;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   assign dis_wr = psel && penable && pwrite && paddr == PRM_RTCCFG_OFF &&
                   pwdata[PRM_LP_DISABLE_BIT];
   // variant is not visible at the ports, so follow the bus writes to it
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) pd_var_q <= 1'b0;
      else if (psel && penable && pwrite && paddr == PRM_SYSCFG_OFF)
         pd_var_q <= pwdata[PRM_PD_VARIANT_BIT];
   end
   sequence resume_s;
      wake_irq_pending ##1 !cpu_halt;
   endsequence
   idle_periph_a: assert property (cpu_halt && core_clk_en |-> periph_clk_en && !wdt_hold)
      else $error("peripherals stopped in idle");
   idle_exit_a: assert property (cpu_halt && core_clk_en && cpu_irq_req |=> !cpu_halt)
      else $error("interrupt did not end idle");
   drain_first_a: assert property ($rose(cpu_halt) |-> !$past(ext_bus_busy))
      else $error("halted with bus busy");
   pd_freeze_a: assert property (!core_clk_en |-> cpu_halt && !periph_clk_en && wdt_hold)
      else $error("power-down not frozen");
   main_osc_a: assert property (
      !core_clk_en && !rtc_ref_low_power |-> main_osc_en == rtc_clk_en)
      else $error("main oscillator wrong in power-down");
   low_osc_a: assert property (!core_clk_en && rtc_ref_low_power |-> !main_osc_en)
      else $error("main oscillator kept with low-power reference");
   lp_keep_a: assert property (
      $fell(rtc_ref_low_power) |-> $past(dis_wr) || $past(dis_wr, 2))
      else $error("low-power reference dropped by itself");
   prot_hold_a: assert property (!core_clk_en && !pd_var_q |=> !core_clk_en)
      else $error("protected power-down left");
   int_wake_a: assert property (
      !core_clk_en && pd_var_q && (rtc_irq || can_irq || i2c_irq) |=> core_clk_en)
      else $error("no wake from interruptible power-down");
   wake_resume_a: assert property ($rose(core_clk_en) |-> resume_s)
      else $error("wake without pending interrupt");
endmodule
bind prm_power_ctrl prm_power_ctrl_checker i_chk (.clock, .nrst, .psel, .penable, .pwrite,
   .paddr, .pwdata, .cpu_irq_req, .ext_bus_busy, .rtc_irq, .can_irq, .i2c_irq, .cpu_halt,
   .core_clk_en, .periph_clk_en, .wdt_hold, .main_osc_en, .rtc_ref_low_power, .rtc_clk_en,
   .wake_irq_pending);

//--- dv/prm_world.sv
// far-side model: external bus unit, ready pin and fast interrupt pins
`timescale 1ns/1ns
module prm_world (
   input wire logic clock,
   input wire logic nrst,
   input wire logic bus_go,
   input wire logic rdy_lvl,
   input wire logic pin_go,
   input wire logic [7:0] hold_mask,
   output logic ext_bus_busy,
   output logic ext_bus_access_end,
   output logic ready_pin,
   output logic [7:0] fast_ext_interrupt_pin
);
   logic [3:0] bus_q;
   logic [1:0] pin_q;
   // one long access, so a mode request can land while it is pending
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) bus_q <= 4'h0;
      else if (bus_go) bus_q <= 4'hc;
      else if (bus_q != 4'h0) bus_q <= bus_q - 4'h1;
   end
   assign ext_bus_busy = bus_q != 4'h0;
   assign ext_bus_access_end = bus_q == 4'h1;
   // ready shown for the whole access, inverted once released
   assign ready_pin = ext_bus_busy ? rdy_lvl : !rdy_lvl;
   // wake pulse held three cycles, longer than the shortest legal one
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) pin_q <= 2'h0;
      else if (pin_go) pin_q <= 2'h3;
      else if (pin_q != 2'h0) pin_q <= pin_q - 2'h1;
   end
   // pin 0 active high, others idle low
   assign fast_ext_interrupt_pin = hold_mask | {7'h0, pin_q != 2'h0};
endmodule

//--- dv/prm_power_ctrl_bench.sv
// self-checking bench for the power reduction mode control
`timescale 1ns/1ns
module prm_power_ctrl_bench import prm_pkg::*; ;
   typedef struct packed {logic [31:0] d; logic e; logic cd;} prm_note_t;
   prm_note_t nq[$];
   logic clock, nrst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, r, hold_mask, fast_ext_interrupt_pin;
   logic [31:0] pwdata, prdata;
   logic idle_instr, power_down_instr, cpu_irq_req, nmi_pin_n, lp_osc_running;
   logic rtc_irq, can_irq, i2c_irq, bus_go, rdy_lvl, pin_go;
   logic ext_bus_busy, ext_bus_access_end, ready_pin;
   logic cpu_halt, core_clk_en, periph_clk_en, wdt_hold, main_osc_en;
   logic rtc_ref_low_power, rtc_clk_en, regulator_off, wake_irq_pending, irq;
   logic [9:0] outs;
   int fails, n_checks;
   assign outs = {cpu_halt, core_clk_en, periph_clk_en, wdt_hold, main_osc_en,
      rtc_ref_low_power, rtc_clk_en, regulator_off, wake_irq_pending, irq};
   prm_power_ctrl #(.EXT_PINS(8)) i_dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .idle_instr, .power_down_instr, .cpu_irq_req,
      .ext_bus_busy, .ext_bus_access_end, .ready_pin, .nmi_pin_n, .fast_ext_interrupt_pin,
      .lp_osc_running, .rtc_irq, .can_irq, .i2c_irq, .cpu_halt, .core_clk_en, .periph_clk_en,
      .wdt_hold, .main_osc_en, .rtc_ref_low_power, .rtc_clk_en, .regulator_off,
      .wake_irq_pending, .irq);
   prm_world i_far (.clock, .nrst, .bus_go, .rdy_lvl, .pin_go, .hold_mask, .ext_bus_busy,
      .ext_bus_access_end, .ready_pin, .fast_ext_interrupt_pin);
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic tally_and_finish;
      if (fails == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask
   // one apb transfer; the expected answer is noted before the request goes out
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] e, input logic er);
      int k;
      nq.push_back('{e, er, !w});
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clock);
         k++;
      end while (pready !== 1'b1 && k < 20);
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 20) begin
         fails++;
         tally_and_finish;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, e, 1'b0);
   endtask
   // one-cycle instruction pulse, then time for the drain and the mode change
   task automatic instr(input logic pd);
      @(posedge clock);
      idle_instr <= !pd;
      power_down_instr <= pd;
      @(posedge clock);
      idle_instr <= 1'b0;
      power_down_instr <= 1'b0;
      step(4);
   endtask
   task automatic go;
      @(posedge clock);
      bus_go <= 1'b1;
      @(posedge clock);
      bus_go <= 1'b0;
   endtask
   // watcher: each completed transfer answers the oldest note
   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1) begin
         if (nq.size() == 0) chk("apb note", 32'h1, 32'h0);
         else begin
            chk("pslverr", {31'h0, nq[0].e}, {31'h0, pslverr});
            if (nq[0].cd) chk("prdata", nq[0].d, prdata);
            void'(nq.pop_front());
         end
      end
   end
   initial begin
      {nrst, psel, penable, pwrite, idle_instr, power_down_instr, cpu_irq_req} = '0;
      {rtc_irq, can_irq, i2c_irq, bus_go, pin_go, lp_osc_running, fails, n_checks} = '0;
      {paddr, pwdata, hold_mask} = '0;
      {nmi_pin_n, rdy_lvl, r} = {2'h3, 8'h35};
      step(16);
      nrst <= 1'b1;
      step(2);
      chk("reset outs", 10'h1a8, outs);
      rd(PRM_SYSCFG_OFF, PRM_SYSCFG_RST);
      rd(PRM_EXTCFG_OFF, PRM_EXTCFG_RST);
      apb(1'b1, 8'h3c, 32'h1, 32'h0, 1'b1);
      apb(1'b0, 8'h3c, 32'h0, 32'h0, 1'b1);
      repeat (3) begin
         r = lfsr(r);
         wr(PRM_SYSCFG_OFF, {4{r}});
         rd(PRM_SYSCFG_OFF, {4{r}});
      end
      wr(PRM_IRQST_OFF, 32'hf);
      rd(PRM_IRQST_OFF, 32'h0);
      wr(PRM_MISC_OFF, 32'h1);
      rd(PRM_MISC_OFF, 32'h1);
      wr(PRM_RTCCFG_OFF, 32'h1);
      rd(PRM_RTCCFG_OFF, 32'h1);
      go;
      instr(1'b0);
      chk("halt while bus busy", 10'h1ac, outs);
      step(10);
      chk("idle", 10'h3ac, outs);
      cpu_irq_req <= 1'b1;
      step(2);
      cpu_irq_req <= 1'b0;
      chk("idle exit", 10'h1ac, outs);
      // ready enabled but missing on the last access
      wr(PRM_BUSCFG_OFF, 32'h3);
      rd(PRM_BUSCFG_OFF, 32'h3);
      rdy_lvl <= 1'b0;
      go;
      step(14);
      wr(PRM_IRQEN_OFF, 32'h1);
      rd(PRM_IRQEN_OFF, 32'h1);
      instr(1'b0);
      chk("refused idle", 10'h1ad, outs);
      rd(PRM_IRQST_OFF, 32'h1);
      wr(PRM_IRQEN_OFF, 32'h0);
      step(2);
      chk("masked irq", 10'h1ac, outs);
      wr(PRM_IRQEN_OFF, 32'h1);
      wr(PRM_IRQCLR_OFF, 32'h1);
      rd(PRM_IRQST_OFF, 32'h0);
      rd(PRM_IRQCLR_OFF, 32'h0);
      rdy_lvl <= 1'b1;
      go;
      step(14);
      wr(PRM_SYSCFG_OFF, 32'h0);
      instr(1'b1);
      chk("nmi high refused", 10'h1ad, outs);
      wr(PRM_IRQCLR_OFF, 32'h1);
      nmi_pin_n <= 1'b0;
      step(3);
      instr(1'b1);
      chk("protected pd", 10'h26c, outs);
      // live state: ready seen, power-down request, protected power-down code
      rd(PRM_STATE_OFF, 32'h56);
      {rtc_irq, can_irq, i2c_irq} <= 3'h7;
      step(6);
      chk("no wake", 10'h26c, outs);
      {rtc_irq, can_irq, i2c_irq, nrst, nmi_pin_n} <= 5'h1;
      step(2);
      nrst <= 1'b1;
      step(2);
      chk("reset exit", 10'h1a8, outs);
      wr(PRM_SYSCFG_OFF, 32'h20);
      wr(PRM_MISC_OFF, 32'h1);
      wr(PRM_EXTCFG_OFF, 32'h101);
      hold_mask <= 8'h01;
      step(3);
      instr(1'b1);
      chk("pin active refused", 10'h1ac, outs);
      hold_mask <= 8'h00;
      step(3);
      // every wake source in turn, rtc counting on and off
      for (int i = 0; i < 4; i++) begin
         wr(PRM_RTCCFG_OFF, {31'h0, i[0]});
         instr(1'b1);
         chk("pd entry", {4'h9, i[0], 1'b0, i[0], 3'h4}, outs);
         pin_go <= (i == 0);
         {rtc_irq, can_irq, i2c_irq} <= 3'(4'h8 >> i);
         step(2);
         {pin_go, rtc_irq, can_irq, i2c_irq} <= 4'h0;
         step(5);
         chk("woken", 10'h1ae, outs);
         cpu_irq_req <= 1'b1;
         step(2);
         cpu_irq_req <= 1'b0;
         chk("pending cleared", 10'h1ac, outs);
      end
      rd(PRM_IRQST_OFF, 32'h3);
      lp_osc_running <= 1'b1;
      step(5);
      chk("low-power ref", 10'h1bc, outs);
      wr(PRM_RTCCFG_OFF, 32'h1);
      instr(1'b1);
      chk("low-power pd", 10'h25c, outs);
      can_irq <= 1'b1;
      step(2);
      can_irq <= 1'b0;
      step(3);
      cpu_irq_req <= 1'b1;
      step(2);
      cpu_irq_req <= 1'b0;
      wr(PRM_RTCCFG_OFF, 32'h3);
      step(3);
      chk("low-power dropped", 10'h1ac, outs);
      // refusal, wakes and the oscillator detection all left their sticky bits
      rd(PRM_IRQST_OFF, 32'h7);
      tally_and_finish;
   end
endmodule
